// ---- cia_regbank.sv ----
// Purpose: host register access path of the CAN protocol controller
// Assumes: host bus is the core register bus, one access per cycle, page in i_sfr_page
// Notes:   read data is registered and valid the cycle after i_sfr_rd
`default_nettype none
module cia_regbank
  import cia_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic [7:0]  i_sfr_page,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic        i_sfr_bit_wr,
  input  wire logic [2:0]  i_sfr_bit_sel,
  input  wire logic        i_sfr_bit_val,
  input  wire logic        i_can_rx,
  input  wire logic [15:0] i_status_set,
  input  wire logic [15:0] i_error_word,
  input  wire logic [15:0] i_interrupt_word,
  input  wire logic [31:0] i_tx_pending,
  input  wire logic [31:0] i_new_data,
  input  wire logic [31:0] i_int_pending,
  input  wire logic [31:0] i_object_valid,
  output logic      [7:0]  o_sfr_rdata,
  output logic      [15:0] o_control_word,
  output logic      [15:0] o_status_word,
  output logic      [15:0] o_bit_timing,
  output logic      [15:0] o_test_word,
  output logic      [15:0] o_prescaler_ext,
  output logic      [7:0]  o_index_selector
);
  logic [15:0] control;
  logic [15:0] status;
  logic [15:0] bit_timing;
  logic [15:0] test;
  logic [15:0] presc_ext;
  logic [7:0]  index_selector;
  logic [7:0]  data_high_byte;
  logic [7:0]  rdata;
  logic        rx_meta;
  logic        rx_sync;

  logic [15:0] next_control;
  logic [15:0] next_status;
  logic [15:0] next_bit_timing;
  logic [15:0] next_test;
  logic [15:0] next_presc_ext;
  logic [7:0]  next_index_selector;
  logic [7:0]  next_data_high_byte;
  logic [7:0]  next_rdata;

  // decode of the current access
  logic        page_hit;
  logic        any_wr;
  logic [7:0]  wr_byte;
  logic [7:0]  cur_byte;
  logic        hit_low;
  logic [6:0]  idx;
  logic        idx_ok;
  logic [15:0] sel_word;
  logic        word_wr;
  logic [15:0] word_val;
  logic [15:0] test_view;

  // interface set hookup
  logic [3:0]   off1;
  logic [3:0]   off2;
  logic         wr1;
  logic         wr2;
  logic [15:0]  rd1;
  logic [15:0]  rd2;
  logic         xfer1;
  logic         xfer2;
  logic         xwr1;
  logic         xwr2;
  logic [4:0]   oidx1;
  logic [4:0]   oidx2;
  logic [143:0] owords1;
  logic [143:0] owords2;
  logic [143:0] ram_rdata;
  logic         ram_we;
  logic [4:0]   ram_idx;
  logic [143:0] ram_wdata;

  function automatic logic in_range(input logic [6:0] v, input logic [6:0] lo,
                                    input logic [6:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] sel,
                                         input logic val);
    logic [7:0] r;
    r      = b;
    r[sel] = val;
    return r;
  endfunction

  assign page_hit  = (i_sfr_page == SFR_PAGE_CAN);
  assign idx       = index_selector[6:0];
  assign idx_ok    = !index_selector[7];
  assign hit_low   = page_hit && (i_sfr_addr == ADDR_DATA_LO);
  assign test_view = {test[15:TEST_RX_BIT+1], rx_sync, test[TEST_RX_BIT-1:0]};

  // word seen through the data bytes
  always_comb begin
    sel_word = RST_ZERO;
    if (idx_ok) begin
      case (idx)
        IDX_CONTROL:       sel_word = control;
        IDX_STATUS:        sel_word = status;
        IDX_ERROR:         sel_word = i_error_word;
        IDX_BIT_TIME:      sel_word = bit_timing;
        IDX_INTERRUPT:     sel_word = i_interrupt_word;
        IDX_TEST:          sel_word = test_view;
        IDX_PRESC_EXT:         sel_word = presc_ext;
        IDX_TX_PEND:           sel_word = i_tx_pending[15:0];
        7'(IDX_TX_PEND + 1):   sel_word = i_tx_pending[31:16];
        IDX_NEW_DATA:          sel_word = i_new_data[15:0];
        7'(IDX_NEW_DATA + 1):  sel_word = i_new_data[31:16];
        IDX_INT_PEND:          sel_word = i_int_pending[15:0];
        7'(IDX_INT_PEND + 1):  sel_word = i_int_pending[31:16];
        IDX_OBJ_VALID:         sel_word = i_object_valid[15:0];
        7'(IDX_OBJ_VALID + 1): sel_word = i_object_valid[31:16];
        default: begin
          if (in_range(idx, IDX_SET1_BASE, IDX_SET1_LAST)) begin
            sel_word = rd1;
          end else if (in_range(idx, IDX_SET2_BASE, IDX_SET2_LAST)) begin
            sel_word = rd2;
          end
        end
      endcase
    end
  end

  // byte as the host sees it at the addressed location
  always_comb begin
    cur_byte = 8'h00;
    if (page_hit) begin
      case (i_sfr_addr)
        ADDR_CONTROL: cur_byte = control[7:0];
        ADDR_TEST:    cur_byte = test_view[7:0];
        ADDR_STATUS:  cur_byte = status[7:0];
        ADDR_INDEX:   cur_byte = index_selector;
        ADDR_DATA_HI: cur_byte = sel_word[15:8];
        ADDR_DATA_LO: cur_byte = sel_word[7:0];
        default:      cur_byte = 8'h00;
      endcase
    end
  end

  // a bit operation is a byte write of the current byte with one bit changed
  assign any_wr  = page_hit && (i_sfr_wr || i_sfr_bit_wr);
  assign wr_byte = i_sfr_bit_wr ? put_bit(cur_byte, i_sfr_bit_sel, i_sfr_bit_val)
                                : i_sfr_wdata;

  // indexed word write; bit ops keep the live high byte, not the staged one
  assign word_wr  = any_wr && hit_low && idx_ok;
  assign word_val = i_sfr_bit_wr ? {sel_word[15:8], wr_byte}
                                 : {data_high_byte, wr_byte};

  assign off1 = 4'(idx - IDX_SET1_BASE);
  assign off2 = 4'(idx - IDX_SET2_BASE);
  assign wr1  = word_wr && in_range(idx, IDX_SET1_BASE, IDX_SET1_LAST);
  assign wr2  = word_wr && in_range(idx, IDX_SET2_BASE, IDX_SET2_LAST);

  always_comb begin
    next_control        = control;
    next_status         = status;
    next_bit_timing     = bit_timing;
    next_test           = test;
    next_presc_ext      = presc_ext;
    next_index_selector = index_selector;
    next_data_high_byte = data_high_byte;
    next_rdata          = rdata;
    if (any_wr) begin
      case (i_sfr_addr)
        ADDR_CONTROL: next_control[7:0] = wr_byte;
        ADDR_TEST:    next_test[7:0]    = wr_byte;
        ADDR_STATUS:  next_status[7:0]  = wr_byte;
        ADDR_INDEX:   next_index_selector = wr_byte;
        ADDR_DATA_HI: next_data_high_byte = wr_byte;
        default:      next_rdata = rdata;
      endcase
    end
    if (word_wr) begin
      case (idx)
        IDX_CONTROL:  next_control = word_val;
        IDX_STATUS:   next_status  = word_val;
        IDX_TEST:     next_test    = word_val;
        IDX_BIT_TIME: begin
          if (control[CTRL_CFG_EN_BIT]) begin
            next_bit_timing = word_val;
          end
        end
        IDX_PRESC_EXT: begin
          if (control[CTRL_TEST_BIT]) begin
            next_presc_ext = word_val;
          end
        end
        // error, interrupt and handler flag words take no writes
        default: next_presc_ext = next_presc_ext;
      endcase
    end
    // engine events win over a host clear in the same cycle
    next_status = next_status | i_status_set;
    // advance on low byte reads and writes only, inside the set ranges
    if (hit_low && (i_sfr_rd || i_sfr_wr || i_sfr_bit_wr) && idx_ok
        && (in_range(idx, IDX_SET1_BASE, IDX_SET1_LAST)
            || in_range(idx, IDX_SET2_BASE, IDX_SET2_LAST))) begin
      next_index_selector = index_selector + INDEX_STEP;
    end
    if (i_sfr_rd) begin
      next_rdata = cur_byte;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      control        <= RST_CONTROL;
      status         <= RST_STATUS;
      bit_timing     <= RST_BIT_TIME;
      test           <= RST_TEST;
      presc_ext      <= RST_PRESC_EXT;
      index_selector <= 8'h00;
      data_high_byte <= 8'h00;
      rdata          <= 8'h00;
      rx_meta        <= 1'b1;
      rx_sync        <= 1'b1;
    end else begin
      control        <= next_control;
      status         <= next_status;
      bit_timing     <= next_bit_timing;
      test           <= next_test;
      presc_ext      <= next_presc_ext;
      index_selector <= next_index_selector;
      data_high_byte <= next_data_high_byte;
      rdata          <= next_rdata;
      rx_meta        <= i_can_rx;
      rx_sync        <= rx_meta;
    end
  end

  cia_if_set u_set_one (
    .i_core_clk  (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_wr        (wr1),
    .i_off       (off1),
    .i_wdata     (word_val),
    .o_rdata     (rd1),
    .o_xfer      (xfer1),
    .o_xfer_wr   (xwr1),
    .o_obj_idx   (oidx1),
    .o_obj_words (owords1),
    .i_obj_words (ram_rdata)
  );

  cia_if_set u_set_two (
    .i_core_clk  (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_wr        (wr2),
    .i_off       (off2),
    .i_wdata     (word_val),
    .o_rdata     (rd2),
    .o_xfer      (xfer2),
    .o_xfer_wr   (xwr2),
    .o_obj_idx   (oidx2),
    .o_obj_words (owords2),
    .i_obj_words (ram_rdata)
  );

  // only one host write per cycle, so the two sets never collide on the RAM
  assign ram_we    = (xfer1 && xwr1) || (xfer2 && xwr2);
  assign ram_idx   = xfer2 ? oidx2 : oidx1;
  assign ram_wdata = xfer2 ? owords2 : owords1;

  cia_msg_ram u_msg_ram (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_we       (ram_we),
    .i_idx      (ram_idx),
    .i_wdata    (ram_wdata),
    .o_rdata    (ram_rdata)
  );

  assign o_sfr_rdata      = rdata;
  assign o_control_word   = control;
  assign o_status_word    = status;
  assign o_bit_timing     = bit_timing;
  assign o_test_word      = test;
  assign o_prescaler_ext  = presc_ext;
  assign o_index_selector = index_selector;
endmodule
`default_nettype wire

// ---- cia_pkg.sv ----
// Purpose: shared constants for the indexed controller register access path
// Assumes: one system clock shared with the processor core
// Notes:   index values are word indices into the 128-word controller space
`default_nettype none
package cia_pkg;
  // host register page and addresses
  localparam logic [7:0]  SFR_PAGE_CAN  = 8'h01;
  localparam logic [7:0]  ADDR_CONTROL  = 8'hF8;
  localparam logic [7:0]  ADDR_TEST     = 8'hDB;
  localparam logic [7:0]  ADDR_STATUS   = 8'hC0;
  localparam logic [7:0]  ADDR_INDEX    = 8'hDA;
  localparam logic [7:0]  ADDR_DATA_HI  = 8'hD9;
  localparam logic [7:0]  ADDR_DATA_LO  = 8'hD8;

  // indexed word map
  localparam int          SPACE_WORDS   = 128;
  localparam logic [6:0]  IDX_CONTROL   = 7'h00;
  localparam logic [6:0]  IDX_STATUS    = 7'h01;
  localparam logic [6:0]  IDX_ERROR     = 7'h02;
  localparam logic [6:0]  IDX_BIT_TIME  = 7'h03;
  localparam logic [6:0]  IDX_INTERRUPT = 7'h04;
  localparam logic [6:0]  IDX_TEST      = 7'h05;
  localparam logic [6:0]  IDX_PRESC_EXT = 7'h06;
  localparam logic [6:0]  IDX_SET1_BASE = 7'h08;
  localparam logic [6:0]  IDX_SET1_LAST = 7'h12;
  localparam logic [6:0]  IDX_SET2_BASE = 7'h20;
  localparam logic [6:0]  IDX_SET2_LAST = 7'h2A;
  localparam logic [6:0]  IDX_TX_PEND   = 7'h40;
  localparam logic [6:0]  IDX_NEW_DATA  = 7'h48;
  localparam logic [6:0]  IDX_INT_PEND  = 7'h50;
  localparam logic [6:0]  IDX_OBJ_VALID = 7'h58;
  localparam logic [7:0]  INDEX_STEP    = 8'h01;

  // reset values
  localparam logic [15:0] RST_CONTROL   = 16'h0001;
  localparam logic [15:0] RST_STATUS    = 16'h0000;
  localparam logic [15:0] RST_BIT_TIME  = 16'h2301;
  localparam logic [15:0] RST_TEST      = 16'h0000;
  localparam logic [15:0] RST_PRESC_EXT = 16'h0000;
  localparam logic [15:0] RST_CMD_REQ   = 16'h0001;
  localparam logic [15:0] RST_MASK      = 16'hFFFF;
  localparam logic [15:0] RST_ZERO      = 16'h0000;

  // field positions
  localparam int          CTRL_CFG_EN_BIT = 6;
  localparam int          CTRL_TEST_BIT = 7;
  localparam int          TEST_RX_BIT   = 7;
  localparam int          CMASK_WR_BIT  = 7;

  // interface set layout
  localparam int          SET_WORDS     = 11;
  localparam int          OBJ_WORDS     = 9;
  localparam int          NUM_OBJECTS   = 32;
  localparam int          OFF_CMD_REQ   = 0;
  localparam int          OFF_CMD_MASK  = 1;
  localparam int          OFF_MASK1     = 2;
  localparam int          OFF_MASK2     = 3;
  localparam int          OFF_OBJ_FIRST = 2;
endpackage
`default_nettype wire

// ---- cia_msg_ram.sv ----
// Purpose: message object store, one whole object per access
// Assumes: at most one transfer request per cycle
// Notes:   flip-flop storage; read is combinational so a load finishes in one cycle
`default_nettype none
module cia_msg_ram
  import cia_pkg::*;
#(
  parameter int OBJECTS = NUM_OBJECTS,
  parameter int WIDTH   = OBJ_WORDS * 16
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_we,
  input  wire logic [$clog2(OBJECTS)-1:0] i_idx,
  input  wire logic [WIDTH-1:0]           i_wdata,
  output logic      [WIDTH-1:0]           o_rdata
);
  logic [WIDTH-1:0] mem      [OBJECTS];
  logic [WIDTH-1:0] next_mem [OBJECTS];

  always_comb begin
    next_mem = mem;
    if (i_we) begin
      next_mem[i_idx] = i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < OBJECTS; i++) begin
        mem[i] <= '0;
      end
    end else begin
      mem <= next_mem;
    end
  end

  assign o_rdata = mem[i_idx];
endmodule
`default_nettype wire

// ---- cia_if_set.sv ----
// Purpose: one message object interface register set with transfer request
// Assumes: command mask direction bit is set up before the request word is written
// Notes:   object numbers outside 1..32 start no transfer
`default_nettype none
module cia_if_set
  import cia_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_wr,
  input  wire logic [3:0]             i_off,
  input  wire logic [15:0]            i_wdata,
  output logic      [15:0]            o_rdata,
  output logic                        o_xfer,
  output logic                        o_xfer_wr,
  output logic      [4:0]             o_obj_idx,
  output logic      [OBJ_WORDS*16-1:0] o_obj_words,
  input  wire logic [OBJ_WORDS*16-1:0] i_obj_words
);
  logic [15:0] words      [SET_WORDS];
  logic [15:0] next_words [SET_WORDS];
  logic [5:0]  obj_num;

  function automatic logic [15:0] reset_word(input int off);
    if (off == OFF_CMD_REQ) begin
      return RST_CMD_REQ;
    end else if (off == OFF_MASK1 || off == OFF_MASK2) begin
      return RST_MASK;
    end
    return RST_ZERO;
  endfunction

  assign obj_num   = i_wdata[5:0];
  assign o_xfer    = i_wr && (int'(i_off) == OFF_CMD_REQ) && (obj_num >= 6'h01)
                     && (obj_num <= 6'(NUM_OBJECTS));
  assign o_xfer_wr = words[OFF_CMD_MASK][CMASK_WR_BIT];
  assign o_obj_idx = 5'(obj_num - 6'h01);
  assign o_rdata   = (int'(i_off) < SET_WORDS) ? words[i_off] : RST_ZERO;

  always_comb begin
    for (int i = 0; i < OBJ_WORDS; i++) begin
      o_obj_words[i*16 +: 16] = words[OFF_OBJ_FIRST + i];
    end
  end

  always_comb begin
    next_words = words;
    if (i_wr && int'(i_off) < SET_WORDS) begin
      next_words[i_off] = i_wdata;
    end
    // read direction: object contents land in the set at the request edge
    if (o_xfer && !o_xfer_wr) begin
      for (int i = 0; i < OBJ_WORDS; i++) begin
        next_words[OFF_OBJ_FIRST + i] = i_obj_words[i*16 +: 16];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < SET_WORDS; i++) begin
        words[i] <= reset_word(i);
      end
    end else begin
      words <= next_words;
    end
  end
endmodule
`default_nettype wire

// ---- cia_regbank_chk.sv ----
// Purpose: bus timing checks on the indexed controller register access path
// Assumes: sees only the ports of cia_regbank, one clock domain
// Notes:   package indices are 7 bits, so compares zero-extend them to the selector
`default_nettype none
module cia_regbank_chk
  import cia_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_sfr_page,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic        i_sfr_bit_wr,
  input wire logic [7:0]  o_sfr_rdata,
  input wire logic [15:0] o_control_word,
  input wire logic [15:0] o_bit_timing,
  input wire logic [15:0] o_prescaler_ext,
  input wire logic [7:0]  o_index_selector
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  logic on_page;
  logic lo_acc;
  logic in_rng;
  assign on_page = (i_sfr_page == SFR_PAGE_CAN);
  assign lo_acc  = on_page && (i_sfr_addr == ADDR_DATA_LO)
                   && (i_sfr_rd || i_sfr_wr || i_sfr_bit_wr);
  assign in_rng  = !o_index_selector[7]
                   && (o_index_selector[6:0] inside {[IDX_SET1_BASE:IDX_SET1_LAST],
                                                     [IDX_SET2_BASE:IDX_SET2_LAST]});

  property p_rd_off;
    i_sfr_rd && !on_page |=> o_sfr_rdata == 8'h00;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("read off page not zero");
  property p_rd_hold;
    !i_sfr_rd |=> $stable(o_sfr_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ctrl_dir;
    on_page && i_sfr_wr && i_sfr_addr == ADDR_CONTROL
      |=> o_control_word[7:0] == $past(i_sfr_wdata);
  endproperty
  a_ctrl_dir: assert property (p_ctrl_dir) else $error("direct write lost");
  property p_ctrl_keep;
    !(on_page && (i_sfr_wr || i_sfr_bit_wr)) |=> $stable(o_control_word);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed unasked");
  property p_inc;
    lo_acc && in_rng |=> o_index_selector == $past(o_index_selector) + INDEX_STEP;
  endproperty
  a_inc: assert property (p_inc) else $error("index did not advance");
  property p_noinc;
    lo_acc && !in_rng |=> $stable(o_index_selector);
  endproperty
  a_noinc: assert property (p_noinc) else $error("index advanced out of range");
  property p_hi_keep;
    on_page && (i_sfr_rd || i_sfr_wr) && i_sfr_addr == ADDR_DATA_HI |=> $stable(o_index_selector);
  endproperty
  a_hi_keep: assert property (p_hi_keep) else $error("high byte moved index");
  property p_bt_lock;
    lo_acc && !i_sfr_rd && o_index_selector == {1'b0, IDX_BIT_TIME}
      && !o_control_word[CTRL_CFG_EN_BIT] |=> $stable(o_bit_timing);
  endproperty
  a_bt_lock: assert property (p_bt_lock) else $error("locked timing written");
  property p_presc_lock;
    lo_acc && !i_sfr_rd && o_index_selector == {1'b0, IDX_PRESC_EXT}
      && !o_control_word[CTRL_TEST_BIT] |=> $stable(o_prescaler_ext);
  endproperty
  a_presc_lock: assert property (p_presc_lock) else $error("locked ext written");
  property p_bt_low;
    on_page && i_sfr_wr && i_sfr_addr == ADDR_DATA_LO && o_index_selector == {1'b0, IDX_BIT_TIME}
      && o_control_word[CTRL_CFG_EN_BIT] |=> o_bit_timing[7:0] == $past(i_sfr_wdata);
  endproperty
  a_bt_low: assert property (p_bt_low) else $error("low byte not committed");
endmodule

bind cia_regbank cia_regbank_chk u_chk (.i_core_clk, .i_reset_n, .i_sfr_page, .i_sfr_addr,
  .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata, .i_sfr_bit_wr, .o_sfr_rdata, .o_control_word,
  .o_bit_timing, .o_prescaler_ext, .o_index_selector);
`default_nettype wire

// ---- cia_core_model.sv ----
// Purpose: processor core side of the register bus, byte and word accesses
// Assumes: strobes change at the falling edge, taken at the next rising edge
// Notes:   one idle cycle between accesses; released lines show inverted values
`default_nettype none
module cia_core_model
  import cia_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_sfr_rdata,
  output var  logic [7:0] o_sfr_page,
  output var  logic [7:0] o_sfr_addr,
  output var  logic       o_sfr_wr,
  output var  logic       o_sfr_rd,
  output var  logic [7:0] o_sfr_wdata,
  output var  logic       o_sfr_bit_wr,
  output var  logic [2:0] o_sfr_bit_sel,
  output var  logic       o_sfr_bit_val
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cur_page = SFR_PAGE_CAN;
  initial begin
    {o_sfr_wr, o_sfr_rd, o_sfr_bit_wr, o_sfr_bit_val, o_sfr_bit_sel} = '0;
    {o_sfr_page, o_sfr_addr, o_sfr_wdata} = {SFR_PAGE_CAN, 16'h0000};
  end
  task access(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r,
              input logic b, input logic [2:0] s, output logic [7:0] q);
    @(negedge i_core_clk);
    {o_sfr_page, o_sfr_addr, o_sfr_wdata} = {cur_page, a, d};
    {o_sfr_wr, o_sfr_rd, o_sfr_bit_wr, o_sfr_bit_sel, o_sfr_bit_val} = {w, r, b, s, d[0]};
    @(negedge i_core_clk);
    q = i_sfr_rdata;
    {o_sfr_wr, o_sfr_rd, o_sfr_bit_wr} = 3'b000;
    {o_sfr_addr, o_sfr_wdata} = ~{o_sfr_addr, o_sfr_wdata};
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(a, d, 1'b1, 1'b0, 1'b0, 3'd0, q);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] q);
    access(a, 8'h00, 1'b0, 1'b1, 1'b0, 3'd0, q);
  endtask
  task bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    logic [7:0] q;
    access(a, {7'h00, v}, 1'b0, 1'b0, 1'b1, s, q);
  endtask
  task wword(input logic [6:0] idx, input logic [15:0] v);
    wr(ADDR_INDEX, {1'b0, idx});
    wr(ADDR_DATA_HI, v[15:8]); // high first, staged until low lands
    wr(ADDR_DATA_LO, v[7:0]);
  endtask
  task rword(input logic [6:0] idx, output logic [15:0] v);
    wr(ADDR_INDEX, {1'b0, idx});
    rd(ADDR_DATA_HI, v[15:8]);
    rd(ADDR_DATA_LO, v[7:0]);
  endtask
endmodule
`default_nettype wire

// ---- tb_cia_regbank.sv ----
// Purpose: self-checking bench for the indexed register access path
// Assumes: host accesses come from cia_core_model tasks
// Notes:   engine side inputs are driven as plain levels from here
`default_nettype none
module tb_cia_regbank
  import cia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_core_clk, i_reset_n, i_can_rx;
  logic [15:0] i_status_set, i_error_word, i_interrupt_word;
  logic [31:0] i_tx_pending, i_new_data, i_int_pending, i_object_valid;
  logic [7:0]  page, addr, wdata, rdata, idx_q;
  logic        wr, rd, bit_wr, bit_val;
  logic [2:0]  bit_sel;
  logic [15:0] ctl, sts, btm, tst, presc;
  int          miscompares = 0;
  int          checks = 0;
  cia_core_model core (.i_core_clk(i_core_clk), .i_sfr_rdata(rdata), .o_sfr_page(page),
    .o_sfr_addr(addr), .o_sfr_wr(wr), .o_sfr_rd(rd), .o_sfr_wdata(wdata),
    .o_sfr_bit_wr(bit_wr), .o_sfr_bit_sel(bit_sel), .o_sfr_bit_val(bit_val));
  cia_regbank dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_sfr_page(page),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .i_sfr_bit_wr(bit_wr), .i_sfr_bit_sel(bit_sel), .i_sfr_bit_val(bit_val),
    .i_can_rx(i_can_rx), .i_status_set(i_status_set), .i_error_word(i_error_word),
    .i_interrupt_word(i_interrupt_word), .i_tx_pending(i_tx_pending),
    .i_new_data(i_new_data), .i_int_pending(i_int_pending), .i_object_valid(i_object_valid),
    .o_sfr_rdata(rdata), .o_control_word(ctl), .o_status_word(sts), .o_bit_timing(btm),
    .o_test_word(tst), .o_prescaler_ext(presc), .o_index_selector(idx_q));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
  initial begin : main
    logic [15:0] w;
    logic [7:0]  b, j;
    static logic [6:0]  ri [6] = '{IDX_CONTROL, IDX_STATUS, IDX_BIT_TIME, IDX_PRESC_EXT,
                                   7'h0A, 7'h23};
    static logic [15:0] rv [6] = '{16'h0001, 16'h0000, 16'h2301, 16'h0000, 16'hFFFF, 16'hFFFF};
    static logic [6:0]  hi [7] = '{IDX_ERROR, IDX_INTERRUPT, 7'h40, 7'h41, 7'h49, IDX_OBJ_VALID,
                                   7'h51};
    static logic [15:0] hv [7] = '{16'h1234, 16'h0042, 16'h5A5A, 16'hA5A5, 16'h0003, 16'h8001,
                                   16'h7E00};
    static logic [7:0]  ai [7] = '{8'h12, 8'h13, 8'h20, 8'h20, 8'h07, 8'h2A, 8'h1F};
    static logic [7:0]  aa [7] = '{ADDR_DATA_LO, ADDR_DATA_LO, ADDR_DATA_HI, ADDR_DATA_LO,
                                   ADDR_DATA_LO, ADDR_DATA_LO, ADDR_DATA_LO};
    static logic [7:0]  ae [7] = '{8'h13, 8'h13, 8'h20, 8'h21, 8'h07, 8'h2B, 8'h1F};
    {i_reset_n, i_can_rx, i_status_set, i_error_word, i_interrupt_word} = {2'b01, 48'h0};
    {i_tx_pending, i_new_data, i_int_pending, i_object_valid} = '0;
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_reset_n = 1'b1;
    i_can_rx = 1'b0;
    chk(btm, RST_BIT_TIME);
    for (int k = 0; k < 6; k++) begin
      core.rword(ri[k], w);
      chk(w, rv[k]);
    end
    core.wr(ADDR_INDEX, 8'h80);
    core.rd(ADDR_DATA_LO, b);
    chk({8'h00, b}, 16'h0000);
    core.wword(IDX_BIT_TIME, 16'h1111);
    chk(btm, 16'h2301);
    core.wword(IDX_PRESC_EXT, 16'h000F);
    chk(presc, 16'h0000);
    core.wr(ADDR_CONTROL, 8'hC1);
    core.rword(IDX_CONTROL, w);
    chk(w, 16'h00C1);
    core.wword(IDX_BIT_TIME, 16'h2304);
    chk(btm, 16'h2304);
    core.wword(IDX_PRESC_EXT, 16'h000F);
    chk(presc, 16'h000F);
    core.wr(ADDR_INDEX, {1'b0, IDX_BIT_TIME});
    core.bwr(ADDR_DATA_LO, 3'd7, 1'b1);
    chk(btm, 16'h2384);
    core.bwr(ADDR_DATA_LO, 3'd2, 1'b0);
    chk(btm, 16'h2380);
    core.wr(ADDR_DATA_LO, 8'h55);
    // staged high byte is still the 00 left by the extension write
    chk(btm, 16'h0055);
    core.cur_page = 8'h02;
    core.wr(ADDR_CONTROL, 8'h00);
    core.rd(ADDR_CONTROL, b);
    chk({ctl[7:0], b}, 16'hC100);
    core.cur_page = SFR_PAGE_CAN;
    core.wr(ADDR_STATUS, 8'h05);
    core.rword(IDX_STATUS, w);
    chk(w, 16'h0005);
    i_status_set = 16'h0100;
    @(negedge i_core_clk);
    i_status_set = 16'h0000;
    chk(sts, 16'h0105);
    core.wr(ADDR_TEST, 8'h12);
    core.rword(IDX_TEST, w);
    chk(w, 16'h0012);
    chk(tst, 16'h0012);
    // rx pin needs two edges through the synchroniser before it shows
    i_can_rx = 1'b1;
    repeat (2) @(negedge i_core_clk);
    core.rd(ADDR_TEST, b);
    chk({8'h00, b}, 16'h0092);
    i_error_word = 16'h1234;
    i_interrupt_word = 16'h0042;
    {i_tx_pending, i_new_data, i_object_valid} = {32'hA5A55A5A, 32'h00030000, 32'h00008001};
    i_int_pending = 32'h7E000000;
    core.wword(IDX_ERROR, 16'hFFFF);
    core.wword(IDX_TX_PEND, 16'h0000);
    for (int k = 0; k < 7; k++) begin
      core.rword(hi[k], w);
      chk(w, hv[k]);
    end
    for (int k = 0; k < 7; k++) begin
      core.wr(ADDR_INDEX, ai[k]);
      core.rd(aa[k], b);
      chk({8'h00, idx_q}, {8'h00, ae[k]});
    end
    core.wword(IDX_SET1_BASE + 7'h01, 16'h0080);
    for (j = 0; j < 9; j++) begin
      core.wr(ADDR_DATA_HI, 8'hB0 + j);
      core.wr(ADDR_DATA_LO, 8'h10 + j);
    end
    chk({8'h00, idx_q}, 16'h0013);
    core.wword(IDX_SET1_BASE, 16'h0005);
    core.wword(IDX_SET2_BASE + 7'h01, 16'h0000);
    core.wword(IDX_SET2_BASE, 16'h0005);
    core.wr(ADDR_INDEX, 8'h22);
    for (j = 0; j < 9; j++) begin
      core.rd(ADDR_DATA_HI, w[15:8]);
      core.rd(ADDR_DATA_LO, w[7:0]);
      chk(w, {8'hB0 + j, 8'h10 + j});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
